// file: hw/sfhi_pkg.sv
// package: constants for the serial flash host interface block
package sfhi_pkg;
  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_WORD = 8'hE7;
  localparam logic [7:0] OP_QUAD_OCT = 8'hE3;
  localparam logic [7:0] OP_FOUR_WIRE_ON = 8'h38;
  localparam logic [7:0] OP_FOUR_WIRE_OFF = 8'hFF;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_PULSE_WIDTH_NS = 1000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_TIME_NS = 30000;
  localparam int RESET_RECOVERY_CYCLES =
    (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int BITS_SERIAL = 8;
  localparam int BITS_FOUR_WIRE = 2;
  localparam logic [7:0] RD_DATA_RESET = 8'hA5;
  typedef enum logic [1:0] {SFHI_W_SINGLE, SFHI_W_DUAL, SFHI_W_QUAD} sfhi_width_t;
endpackage : sfhi_pkg

// file: hw/sfhi_top.sv
// module: serial flash host interface, link side and core side
// ----------------------------------------
// Summary of operation
// RULE_01: sample inputs on rising link clock, launch outputs on falling link clock.
// RULE_02: modes 0 and 3 both accepted; idle clock level is irrelevant.
// RULE_03: dual reads 3B/BB use io_line_0 and io_line_1 both ways.
// RULE_04: quad reads use all four lines; protect and pause pins become io 2/3. In serial mode the code leaves E3h at single width.
// RULE_05: quad-data instructions run only while quad_enable_bit is set.
// RULE_06: 38h enters four_wire_command_mode, FFh leaves; only one mode active.
// RULE_07: instruction takes two clocks on four lines, eight on one line.
// RULE_08: power-up, software or hardware reset leaves serial mode.
// RULE_09: entry to four_wire_command_mode needs quad_enable_bit set.
// RULE_10: pause honoured only in single or dual operation while selected.
// RULE_11: pause starts at pause fall with clock low, else next falling clock.
// RULE_12: pause ends at pause rise with clock low, else next falling clock.
// RULE_13: paused: output floats, clock and input ignored, state kept.
// RULE_14: master keeps select low through a pause; release resets interface.
// RULE_15: software reset is 66h immediately followed by 99h, in either mode.
// RULE_16: after software reset, power-on state, commands refused for recovery time.
// RULE_17: shared pin is pause when select bit 0, reset input when 1.
// RULE_18: reset pin low at least 1us resets; no commands while it is low.
// RULE_19: quad_enable_bit set disables pause and reset on the shared pin.
// RULE_20: dedicated reset pin works regardless of select and quad bits.
// RULE_21: hardware reset overrides every other input.
// RULE_22: master should wait for busy_flag clear before any reset.
// RULE_23: select high ignores activity; select fall restarts decoding.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module sfhi_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic IO0_I,
  input wire logic IO1_I,
  input wire logic IO2_I,
  input wire logic IO3_I,
  input wire logic RESET_N_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic PIN_FUNCTION_SELECT_I,
  input wire logic BUSY_FLAG_I,
  output logic IO0_O,
  output logic IO1_O,
  output logic IO2_O,
  output logic IO3_O,
  output logic IO0_OE_N_O,
  output logic IO1_OE_N_O,
  output logic IO2_OE_N_O,
  output logic IO3_OE_N_O,
  output logic FOUR_WIRE_MODE_O,
  output logic PAUSED_O,
  output logic RESETTING_O,
  output logic [7:0] OPCODE_O,
  output logic OPCODE_VALID_O
);
  // ----------------------------------------
  // core-domain pin filters
  // ----------------------------------------
  logic [2:0] rstp_s_q;
  logic [2:0] shp_s_q;
  logic [2:0] sck_s_q;
  logic [2:0] csn_s_q;
  logic rstp_q;
  logic shp_q;
  logic sck_q;
  logic csn_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rstp_s_q <= 3'h7;
      shp_s_q <= 3'h7;
      sck_s_q <= 3'h0;
      csn_s_q <= 3'h7;
      rstp_q <= 1'b1;
      shp_q <= 1'b1;
      sck_q <= 1'b0;
      csn_q <= 1'b1;
    end else begin
      rstp_s_q <= {rstp_s_q[1:0], RESET_N_I};
      shp_s_q <= {shp_s_q[1:0], IO3_I};
      sck_s_q <= {sck_s_q[1:0], SCLK_I};
      csn_s_q <= {csn_s_q[1:0], CS_N_I};
      if (rstp_s_q[1] == rstp_s_q[2]) rstp_q <= rstp_s_q[2];
      if (shp_s_q[1] == shp_s_q[2]) shp_q <= shp_s_q[2];
      if (sck_s_q[1] == sck_s_q[2]) sck_q <= sck_s_q[2];
      if (csn_s_q[1] == csn_s_q[2]) csn_q <= csn_s_q[2];
    end
  end
  // ----------------------------------------
  // hardware reset pulse qualification
  // ----------------------------------------
  logic shared_rst_low;
  logic [sfhi_pkg::CNT_W-1:0] rst_low_cnt_q;
  logic hw_reset_q;
  logic [sfhi_pkg::CNT_W-1:0] recov_cnt_q;
  logic resetting_q;
  logic sw_reset_tgl_q;
  logic [2:0] sw_tgl_s_q;
  logic sw_reset_evt;
  // shared pin acts as reset only with select set and quad bit clear
  assign shared_rst_low = PIN_FUNCTION_SELECT_I
    && !QUAD_ENABLE_BIT_I // see RULE_19
    && !shp_q; // see RULE_17
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_low_cnt_q <= '0;
      hw_reset_q <= 1'b0;
    end else if (!rstp_q || shared_rst_low) begin // see RULE_20
      if (rst_low_cnt_q != sfhi_pkg::CNT_W'(sfhi_pkg::RESET_PULSE_CYCLES - 1)) begin
        rst_low_cnt_q <= rst_low_cnt_q + 1'b1;
      end else begin
        hw_reset_q <= 1'b1; // see RULE_18
      end
    end else begin
      rst_low_cnt_q <= '0;
      hw_reset_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // software reset arrival and recovery
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sw_tgl_s_q <= 3'h0;
    end else begin
      sw_tgl_s_q <= {sw_tgl_s_q[1:0], sw_reset_tgl_q};
    end
  end
  assign sw_reset_evt = sw_tgl_s_q[2] ^ sw_tgl_s_q[1];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      recov_cnt_q <= '0;
      resetting_q <= 1'b1;
    end else if (hw_reset_q) begin // see RULE_21
      recov_cnt_q <= '0;
      resetting_q <= 1'b1;
    end else if (sw_reset_evt) begin // see RULE_16
      recov_cnt_q <= '0;
      resetting_q <= 1'b1;
    end else if (resetting_q) begin
      if (recov_cnt_q == sfhi_pkg::CNT_W'(sfhi_pkg::RESET_RECOVERY_CYCLES - 1)) begin
        resetting_q <= 1'b0;
      end else begin
        recov_cnt_q <= recov_cnt_q + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // pause detection
  // ----------------------------------------
  logic pause_allowed;
  logic paused_q;
  logic quad_op_q;
  logic [1:0] qop_s_q;
  logic [1:0] fw_s_q;
  logic fw_mode_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) qop_s_q <= 2'h0;
    else qop_s_q <= {qop_s_q[0], quad_op_q};
  end
  assign pause_allowed = !csn_q && !QUAD_ENABLE_BIT_I && !PIN_FUNCTION_SELECT_I
    && !fw_s_q[1] && !qop_s_q[1]; // see RULE_10
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) fw_s_q <= 2'h0;
    else fw_s_q <= {fw_s_q[0], fw_mode_q};
  end
  logic sck_prev_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) sck_prev_q <= 1'b0;
    else sck_prev_q <= sck_q;
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      paused_q <= 1'b0;
    end else if (!pause_allowed || resetting_q) begin
      paused_q <= 1'b0; // see RULE_14
    end else if (!sck_q && (sck_prev_q || paused_q != !shp_q)) begin
      paused_q <= !shp_q; // see RULE_11 see RULE_12
    end
  end
  // ----------------------------------------
  // link domain: instruction shifter
  // ----------------------------------------
  logic [2:0] pz_s_q;
  logic [2:0] rb_s_q;
  logic link_paused;
  logic link_block;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;
  logic have_op_q;
  logic rst_en_q;
  logic [7:0] op_q;
  logic op_tgl_q;
  logic link_rst;
  // only rising edges shift, so either idle clock level works
  assign link_rst = RST_I // see RULE_02
    || CS_N_I // see RULE_23
    || resetting_q; // see RULE_16
  always_ff @(posedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      pz_s_q <= 3'h0;
      rb_s_q <= 3'h0;
    end else begin
      pz_s_q <= {pz_s_q[1:0], paused_q};
      rb_s_q <= {rb_s_q[1:0], resetting_q};
    end
  end
  assign link_paused = pz_s_q[2];
  assign link_block = rb_s_q[2];
  always_ff @(posedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      shift_q <= '0;
      bit_cnt_q <= '0;
      have_op_q <= 1'b0;
    end else if (!link_paused && !have_op_q && !link_block) begin // see RULE_13 see RULE_01
      if (fw_mode_q) begin
        shift_q <= {shift_q[3:0], IO3_I, IO2_I, IO1_I, IO0_I}; // see RULE_07
        if (bit_cnt_q == 3'(sfhi_pkg::BITS_FOUR_WIRE - 1)) have_op_q <= 1'b1;
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end else begin
        shift_q <= {shift_q[6:0], IO0_I}; // see RULE_07
        if (bit_cnt_q == 3'(sfhi_pkg::BITS_SERIAL - 1)) have_op_q <= 1'b1;
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // link domain: opcode decode and mode
  // ----------------------------------------
  logic [7:0] cur_op;
  assign cur_op = fw_mode_q ? {shift_q[3:0], IO3_I, IO2_I, IO1_I, IO0_I}
                            : {shift_q[6:0], IO0_I};
  logic last_bit;
  assign last_bit = !link_paused && !have_op_q && !link_block && (fw_mode_q ?
    bit_cnt_q == 3'(sfhi_pkg::BITS_FOUR_WIRE - 1) : bit_cnt_q == 3'(sfhi_pkg::BITS_SERIAL - 1));
  logic sw_rst_link;
  logic [1:0] hr_s_q;
  always_ff @(posedge SCLK_I or posedge RST_I) begin
    if (RST_I) hr_s_q <= 2'h0;
    else hr_s_q <= {hr_s_q[0], hw_reset_q};
  end
  assign sw_rst_link = last_bit && rst_en_q && cur_op == sfhi_pkg::OP_RESET;
  always_ff @(posedge SCLK_I or posedge RST_I) begin
    if (RST_I) begin
      fw_mode_q <= 1'b0;
      rst_en_q <= 1'b0;
      op_q <= '0;
      op_tgl_q <= 1'b0;
      sw_reset_tgl_q <= 1'b0;
      quad_op_q <= 1'b0;
    end else if (hr_s_q[1]) begin
      fw_mode_q <= 1'b0; // see RULE_08
      rst_en_q <= 1'b0;
      quad_op_q <= 1'b0;
    end else if (last_bit) begin
      op_q <= cur_op;
      op_tgl_q <= !op_tgl_q;
      rst_en_q <= cur_op == sfhi_pkg::OP_RESET_ENABLE; // see RULE_15
      quad_op_q <= QUAD_ENABLE_BIT_I && (cur_op == sfhi_pkg::OP_QUAD_OUT
        || cur_op == sfhi_pkg::OP_QUAD_IO || cur_op == sfhi_pkg::OP_QUAD_WORD
        || cur_op == sfhi_pkg::OP_QUAD_OCT); // see RULE_05
      if (sw_rst_link) begin
        fw_mode_q <= 1'b0; // see RULE_08
        sw_reset_tgl_q <= !sw_reset_tgl_q;
      end else if (cur_op == sfhi_pkg::OP_FOUR_WIRE_ON && QUAD_ENABLE_BIT_I) begin
        fw_mode_q <= 1'b1; // see RULE_06 see RULE_09
      end else if (cur_op == sfhi_pkg::OP_FOUR_WIRE_OFF) begin
        fw_mode_q <= 1'b0; // see RULE_06
      end
    end else if (CS_N_I) begin
      quad_op_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // link domain: data width and output launch
  // ----------------------------------------
  sfhi_pkg::sfhi_width_t width_q;
  always_ff @(posedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      width_q <= sfhi_pkg::SFHI_W_SINGLE;
    end else if (last_bit) begin
      if (fw_mode_q) width_q <= sfhi_pkg::SFHI_W_QUAD;
      else if (cur_op == sfhi_pkg::OP_DUAL_OUT || cur_op == sfhi_pkg::OP_DUAL_IO) begin
        width_q <= sfhi_pkg::SFHI_W_DUAL; // see RULE_03
      end else if (QUAD_ENABLE_BIT_I && (cur_op == sfhi_pkg::OP_QUAD_OUT
        || cur_op == sfhi_pkg::OP_QUAD_IO || cur_op == sfhi_pkg::OP_QUAD_WORD)) begin
        width_q <= sfhi_pkg::SFHI_W_QUAD; // see RULE_04 see RULE_05
      end
    end
  end
  logic [7:0] rd_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_n_q;
  always_ff @(negedge SCLK_I or posedge link_rst) begin
    if (link_rst) begin
      rd_q <= sfhi_pkg::RD_DATA_RESET;
      io_out_q <= 4'h0;
      io_oe_n_q <= 4'hF;
    end else if (link_paused) begin
      io_oe_n_q <= 4'hF; // see RULE_13
    end else if (have_op_q && !link_block) begin // see RULE_01
      case (width_q)
        sfhi_pkg::SFHI_W_DUAL: begin
          io_out_q <= {2'b00, rd_q[7:6]};
          io_oe_n_q <= 4'hC;
          rd_q <= {rd_q[5:0], rd_q[7:6]};
        end
        sfhi_pkg::SFHI_W_QUAD: begin
          io_out_q <= rd_q[7:4];
          io_oe_n_q <= 4'h0;
          rd_q <= {rd_q[3:0], rd_q[7:4]};
        end
        default: begin
          io_out_q <= {2'b00, rd_q[7], 1'b0};
          io_oe_n_q <= 4'hD;
          rd_q <= {rd_q[6:0], rd_q[7]};
        end
      endcase
    end
  end
  // ----------------------------------------
  // core domain: opcode report
  // ----------------------------------------
  logic [2:0] ot_s_q;
  logic op_evt;
  logic quad_cmd;
  // quad-data instructions are refused while the quad bit is clear
  assign quad_cmd = op_q == sfhi_pkg::OP_QUAD_OUT
    || op_q == sfhi_pkg::OP_QUAD_IO
    || op_q == sfhi_pkg::OP_QUAD_WORD
    || op_q == sfhi_pkg::OP_QUAD_OCT;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) ot_s_q <= 3'h0;
    else ot_s_q <= {ot_s_q[1:0], op_tgl_q};
  end
  assign op_evt = ot_s_q[2] ^ ot_s_q[1];
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      OPCODE_O <= 8'h00;
      OPCODE_VALID_O <= 1'b0;
      FOUR_WIRE_MODE_O <= 1'b0;
      PAUSED_O <= 1'b0;
      RESETTING_O <= 1'b1;
    end else begin
      OPCODE_VALID_O <= op_evt && !resetting_q && !BUSY_FLAG_I // see RULE_22
        && (QUAD_ENABLE_BIT_I || !quad_cmd); // see RULE_05
      if (op_evt) OPCODE_O <= op_q;
      FOUR_WIRE_MODE_O <= fw_s_q[1];
      PAUSED_O <= paused_q;
      RESETTING_O <= resetting_q;
    end
  end
  // outputs launched directly by the link flops
  assign IO0_O = io_out_q[0];
  assign IO1_O = io_out_q[1];
  assign IO2_O = io_out_q[2];
  assign IO3_O = io_out_q[3];
  assign IO0_OE_N_O = io_oe_n_q[0];
  assign IO1_OE_N_O = io_oe_n_q[1];
  assign IO2_OE_N_O = io_oe_n_q[2];
  assign IO3_OE_N_O = io_oe_n_q[3];
endmodule : sfhi_top
`default_nettype wire

// file: dv/sfhi_props.sv
// checker: port-level properties of the flash interface
`timescale 1ns/1ps
`default_nettype none
module sfhi_props (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic RESET_N_I,
  input wire logic IO3_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic PIN_FUNCTION_SELECT_I,
  input wire logic IO1_OE_N_O,
  input wire logic FOUR_WIRE_MODE_O,
  input wire logic PAUSED_O,
  input wire logic RESETTING_O,
  input wire logic [7:0] OPCODE_O,
  input wire logic OPCODE_VALID_O
);
  // ---
  // helper counters
  // ---
  localparam int REC = sfhi_pkg::RESET_RECOVERY_CYCLES;
  localparam int PW = sfhi_pkg::RESET_PULSE_CYCLES;
  logic [11:0] hold_q;
  logic [11:0] pin_q;
  logic pin_low;
  logic [6:0] pl_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) pl_q <= 7'h00;
    else pl_q <= {pl_q[5:0], pin_low};
  end
  assign pin_low = !RESET_N_I || (PIN_FUNCTION_SELECT_I && !QUAD_ENABLE_BIT_I && !IO3_I);
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) hold_q <= 12'h000;
    else hold_q <= (!RESETTING_O || pin_low || |pl_q) ? 12'h000
      : hold_q + 12'(hold_q != 12'hFFF);
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) pin_q <= 12'h000;
    else pin_q <= RESET_N_I ? 12'h000 : pin_q + 12'(pin_q != 12'hFFF);
  end
  // ---
  // properties
  // ---
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_settled; RESETTING_O ##1 RESETTING_O; endsequence
  sequence s_enter; $rose(FOUR_WIRE_MODE_O) ##0 QUAD_ENABLE_BIT_I; endsequence
  property p_refuse; RESETTING_O |-> !OPCODE_VALID_O; endproperty
  a_refuse: assert property (p_refuse) else $error("opcode taken in reset");
  property p_recover; $fell(RESETTING_O) |-> int'(hold_q) inside {[REC - 3:REC + 5]}; endproperty
  a_recover: assert property (p_recover) else $error("recovery length");
  property p_enter; $rose(FOUR_WIRE_MODE_O) |-> s_enter ##[0:6] OPCODE_O == 8'h38; endproperty
  a_enter: assert property (p_enter) else $error("bad mode entry");
  property p_leave; $fell(FOUR_WIRE_MODE_O) |-> ##[0:6] (OPCODE_O == 8'hFF || RESETTING_O);
  endproperty
  a_leave: assert property (p_leave) else $error("bad mode exit");
  property p_one_mode; s_settled |-> !FOUR_WIRE_MODE_O; endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode kept in reset");
  property p_gate; PAUSED_O |-> !QUAD_ENABLE_BIT_I && !PIN_FUNCTION_SELECT_I && !FOUR_WIRE_MODE_O;
  endproperty
  a_gate: assert property (p_gate) else $error("pause not allowed");
  property p_float; PAUSED_O && $past(PAUSED_O) |-> IO1_OE_N_O; endproperty
  a_float: assert property (p_float) else $error("driving while paused");
  property p_quad; OPCODE_VALID_O && OPCODE_O inside {8'h6B, 8'hEB, 8'hE7, 8'hE3}
    |-> QUAD_ENABLE_BIT_I; endproperty
  a_quad: assert property (p_quad) else $error("quad op without enable");
  property p_pin; int'(pin_q) == PW + 8 |-> RESETTING_O; endproperty
  a_pin: assert property (p_pin) else $error("reset pin ignored");
endmodule : sfhi_props
`default_nettype wire

// file: dv/sfhi_master_model.sv
// partner: behavioural bus master for the flash interface
`timescale 1ns/1ps
`default_nettype none
module sfhi_master_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'hF;
  end
  // ---
  // frame and pin tasks
  // ---
  task automatic frame(input logic [7:0] b, input logic four, input logic m3, input logic pz);
    int n;
    n = four ? 2 : 8;
    sclk_o = m3;
    #80;
    cs_n_o = 1'b0;
    #80;
    for (int k = 0; k < n; k++) begin
      sclk_o = 1'b0;
      if (four) io_o = (k == 0) ? b[7:4] : b[3:0];
      else io_o[0] = b[7 - k];
      if (pz && k == 4) begin
        io_o[3] = 1'b0;
        #2000;
        io_o[3] = 1'b1;
        #400;
      end
      #80;
      sclk_o = 1'b1;
      #80;
    end
    if (!m3) sclk_o = 1'b0;
    #80;
    cs_n_o = 1'b1;
    io_o = {1'b1, ~io_o[2:0]};
  endtask : frame
  task automatic set3(input logic v);
    io_o[3] = v;
  endtask : set3
endmodule : sfhi_master_model
`default_nettype wire

// file: dv/testbench.sv
// testbench: directed scenarios for the flash interface
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, rst_n, quad, pfs, busy, sclk, cs_n, seen, fw, paused, resetting, valid;
  logic [3:0] m_io, io_i, io_o, oe_n;
  logic [7:0] opcode, got;
  int error_cnt, check_count;
  // ---
  // design, partner, wires
  // ---
  assign io_i = (oe_n & m_io) | (~oe_n & io_o);
  sfhi_master_model u_master (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(m_io));
  sfhi_top u_dut (
    .CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
    .IO0_I(io_i[0]), .IO1_I(io_i[1]), .IO2_I(io_i[2]), .IO3_I(io_i[3]),
    .RESET_N_I(rst_n), .QUAD_ENABLE_BIT_I(quad), .PIN_FUNCTION_SELECT_I(pfs),
    .BUSY_FLAG_I(busy), .IO0_O(io_o[0]), .IO1_O(io_o[1]), .IO2_O(io_o[2]),
    .IO3_O(io_o[3]), .IO0_OE_N_O(oe_n[0]), .IO1_OE_N_O(oe_n[1]),
    .IO2_OE_N_O(oe_n[2]), .IO3_OE_N_O(oe_n[3]), .FOUR_WIRE_MODE_O(fw),
    .PAUSED_O(paused), .RESETTING_O(resetting), .OPCODE_O(opcode), .OPCODE_VALID_O(valid));
  // ---
  // shared tasks
  // ---
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] b, input logic four, input logic m3, input logic pz);
    seen = 1'b0;
    fork
      u_master.frame(b, four, m3, pz);
      for (int i = 0; i < 200 && !seen; i++) begin
        @(posedge clk);
        #1;
        if (valid === 1'b1) begin
          seen = 1'b1;
          got = opcode;
        end
      end
    join
    repeat (4) @(negedge clk);
  endtask : xfer
  task automatic wait_rec();
    int n;
    n = 0;
    while (resetting !== 1'b0 && n < 700) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n < 700), 8'h01, "recovery end");
    if (n >= 700) end_of_test();
  endtask : wait_rec
  task automatic pin_wait(input logic v);
    u_master.set3(v);
    repeat (30) @(negedge clk);
  endtask : pin_wait
  // ---
  // scenarios
  // ---
  task automatic t_reset();
    repeat (8) @(negedge clk);
    chk(8'(resetting), 8'h01, "reset flag");
    chk(8'(fw), 8'h00, "mode after reset");
    chk(8'(oe_n), 8'h0F, "lines released");
    rst = 1'b0;
    wait_rec();
    $display("test reset done");
  endtask : t_reset
  task automatic t_serial();
    xfer(8'h3B, 1'b0, 1'b0, 1'b0);
    chk(got, 8'h3B, "mode 0 opcode");
    xfer(8'hBB, 1'b0, 1'b1, 1'b0);
    chk(got, 8'hBB, "mode 3 opcode");
    $display("test serial done");
  endtask : t_serial
  task automatic t_quad();
    xfer(8'h38, 1'b0, 1'b0, 1'b0);
    chk(8'(fw), 8'h00, "entry refused");
    xfer(8'h6B, 1'b0, 1'b0, 1'b0);
    chk(8'(seen), 8'h00, "quad op refused");
    quad = 1'b1;
    xfer(8'h38, 1'b0, 1'b1, 1'b0);
    chk(8'(fw), 8'h01, "entry taken");
    xfer(8'hEB, 1'b1, 1'b0, 1'b0);
    chk(got, 8'hEB, "two-clock opcode");
    xfer(8'hFF, 1'b1, 1'b1, 1'b0);
    chk(8'(fw), 8'h00, "exit taken");
    $display("test quad done");
  endtask : t_quad
  task automatic t_swreset();
    xfer(8'h66, 1'b0, 1'b0, 1'b0);
    xfer(8'h3B, 1'b0, 1'b0, 1'b0);
    xfer(8'h99, 1'b0, 1'b0, 1'b0);
    chk(8'(resetting), 8'h00, "broken pair");
    xfer(8'h38, 1'b0, 1'b0, 1'b0);
    xfer(8'h66, 1'b1, 1'b0, 1'b0);
    xfer(8'h99, 1'b1, 1'b0, 1'b0);
    chk(8'(resetting), 8'h01, "reset started");
    chk(8'(fw), 8'h00, "serial after reset");
    xfer(8'h3B, 1'b0, 1'b0, 1'b0);
    chk(8'(seen), 8'h00, "refused in recovery");
    wait_rec();
    $display("test software reset done");
  endtask : t_swreset
  task automatic t_pause();
    for (int q = 0; q < 2; q++) begin
      quad = 1'(q);
      fork
        xfer(8'hBB, 1'b0, 1'b0, 1'b1);
        #1300 chk(8'(paused), 8'(q == 0), "pause state");
      join
      chk(got, 8'hBB, "resumed opcode");
      chk(8'(paused), 8'h00, "pause ended");
    end
    $display("test pause done");
  endtask : t_pause
  task automatic t_hwreset();
    pfs = 1'b1;
    pin_wait(1'b0);
    chk(8'(resetting), 8'h00, "shared pin as data");
    rst_n = 1'b0;
    repeat (30) @(negedge clk);
    chk(8'(resetting), 8'h01, "dedicated pin");
    rst_n = 1'b1;
    u_master.set3(1'b1);
    wait_rec();
    quad = 1'b0;
    pin_wait(1'b0);
    chk(8'(resetting), 8'h01, "shared pin reset");
    u_master.set3(1'b1);
    wait_rec();
    $display("test hardware reset done");
  endtask : t_hwreset
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    rst_n = 1'b1;
    quad = 1'b0;
    pfs = 1'b0;
    busy = 1'b0;
    error_cnt = 0;
    check_count = 0;
    t_reset();
    t_serial();
    t_quad();
    t_swreset();
    t_pause();
    t_hwreset();
    end_of_test();
  end
endmodule : testbench
bind sfhi_top sfhi_props u_props (.CLK_I(CLK_I), .RST_I(RST_I), .RESET_N_I(RESET_N_I),
  .IO3_I(IO3_I), .QUAD_ENABLE_BIT_I(QUAD_ENABLE_BIT_I), .IO1_OE_N_O(IO1_OE_N_O),
  .PIN_FUNCTION_SELECT_I(PIN_FUNCTION_SELECT_I), .FOUR_WIRE_MODE_O(FOUR_WIRE_MODE_O),
  .PAUSED_O(PAUSED_O), .RESETTING_O(RESETTING_O), .OPCODE_O(OPCODE_O),
  .OPCODE_VALID_O(OPCODE_VALID_O));
`default_nettype wire
